// ---- hbbc_regs.svh ----
// Register map, field positions, reset values and timing counts of the host port
`ifndef HBBC_REGS_SVH
`define HBBC_REGS_SVH

// Byte offsets of the registers
`define HBBC_OFF_ID        8'h00
`define HBBC_OFF_GCR1      8'h02
`define HBBC_OFF_GCR2      8'h04
`define HBBC_OFF_GIOCR     8'h0a
`define HBBC_OFF_PCR1      8'h40
`define HBBC_OFF_PCR2      8'h42
`define HBBC_OFF_PCR3      8'h44
`define HBBC_OFF_PCR4      8'h46
`define HBBC_OFF_FIFOHEC   8'h48
`define HBBC_OFF_STAT      8'h4a
`define HBBC_PORT_BASE     8'h40

// Global control one fields
`define HBBC_GCR1_RST      0
`define HBBC_GCR1_DPHOLD   1
`define HBBC_GCR1_LCM      2
`define HBBC_GCR1_IFT      8
`define HBBC_GCR1_BUSW     10
`define HBBC_GCR1_RST_VAL  16'h0003

// Port control fields
`define HBBC_PCR1_DPHOLD   0
`define HBBC_PCR1_PD       1
`define HBBC_PCR1_HDLC_PATH_SELECT    4
`define HBBC_PCR1_LINE_ALARM_DISABLE     10
`define HBBC_PCR1_PAYLOAD_ALARM_DISABLE     12
`define HBBC_PCR1_RST_VAL  16'h0003
`define HBBC_PCR2_TX_LINE_ENABLE     0
`define HBBC_PCR2_FM       1
`define HBBC_PCR2_CELL_IN_PACKET_MODE_ENABLE    7
`define HBBC_PCR2_LM       8
`define HBBC_PCR3_LOOP_TIMING_SELECT    0
`define HBBC_PCR3_TX_CLOCK_SOURCE_SELECT    1
`define HBBC_FH_TX_FIFO_CLEAR      0
`define HBBC_FH_RX_FIFO_CLEAR      1
`define HBBC_FH_TX_HEADER_CHECK_PASS      2
`define HBBC_FH_RX_HEADER_CHECK_PASS      3
`define HBBC_ZERO_VAL      16'h0000

// Field widths
`define HBBC_W_IFT         2
`define HBBC_W_BUSW        2
`define HBBC_W_LINE_ALARM_DISABLE        2
`define HBBC_W_PAYLOAD_ALARM_DISABLE        3
`define HBBC_W_FM          6
`define HBBC_W_LM          4

// Wait counts loaded when the access is taken; the register access follows count plus one cycles later
`define HBBC_GLB_WAIT_CYC  3'h1
`define HBBC_PORT_WAIT_CYC 3'h3

`endif

// ---- hbbc_pkg.sv ----
// Types shared by the host port design
`default_nettype none
package hbbc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE, ST_HOLD} hbbc_state_e;
  typedef enum logic [1:0] {TXCLK_RATE_ADAPTER, TXCLK_INPUT, TXCLK_LOOP_RX} hbbc_txclk_e;
endpackage : hbbc_pkg
`default_nettype wire

// ---- hbbc_sync.sv ----
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module hbbc_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : hbbc_sync
`default_nettype wire

// ---- hbbc_host_port.sv ----
// Asynchronous host processor port with the bring-up configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "hbbc_regs.svh"
module hbbc_host_port #(
  parameter int          ADDR_W  = 7,
  parameter int          EVT_W   = 16,
  parameter logic [15:0] CHIP_ID = 16'h005a  // Arbitrary identity value
) (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic              width_sel_pin,
  input  wire logic              addr_lsb_or_swap_pin,
  input  wire logic              strobe_mode_pin,
  input  wire logic              cs_n,
  input  wire logic              rd_n,
  input  wire logic              wr_n,
  input  wire logic              ds_n,
  input  wire logic              rw_dir,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [15:0]       data_in,
  output var  logic [15:0]       data_out,
  output var  logic [1:0]        data_oe,
  output var  logic              rdy_n,
  input  wire logic [EVT_W-1:0]  status_event,
  output var  logic              device_run,
  output var  logic [1:0]        sys_if_type,
  output var  logic [1:0]        sys_bus_width,
  output var  logic              global_datapath_hold,
  output var  logic              port_datapath_hold,
  output var  logic              port_power_down,
  output var  logic [15:0]       clock_rate_adapter_config,
  output var  logic [15:0]       gio_config,
  output var  logic [15:0]       port_aux_config,
  output var  logic [2:0]        payload_alarm_disable,
  output var  logic [1:0]        line_alarm_disable,
  output var  logic              hdlc_path_select,
  output var  logic [3:0]        line_interface_mode,
  output var  logic [5:0]        framing_protocol_field,
  output var  logic              cell_in_packet_mode_enable,
  output var  logic              tx_line_enable,
  output var  logic [1:0]        tx_clock_pick,
  output var  logic              tx_fifo_clear,
  output var  logic              rx_fifo_clear,
  output var  logic              hec_pass_through
);
  // ==========================================================
  // Reset release and pin synchronisers
  logic rst_meta;
  logic rst_n_s;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta <= 1'b0;
      rst_n_s  <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n_s  <= rst_meta;
    end
  end

  logic [7:0]         ctl_q;
  logic [ADDR_W-1:0]  addr_q;
  logic [15:0]        data_q;

  hbbc_sync #(.W(8), .RST_VAL(8'hff)) u_sync_ctl (
    .mclk  (mclk),
    .rst_n (rst_n_s),
    .d     ({cs_n, rd_n, wr_n, ds_n, rw_dir, width_sel_pin,
             addr_lsb_or_swap_pin, strobe_mode_pin}),
    .q     (ctl_q)
  );

  hbbc_sync #(.W(ADDR_W + 16)) u_sync_bus (
    .mclk  (mclk),
    .rst_n (rst_n_s),
    .d     ({addr, data_in}),
    .q     ({addr_q, data_q})
  );

  logic cs_q, rd_q, wr_q, ds_q, rw_q, w16_q, lsb_q, mode_q;
  assign {cs_q, rd_q, wr_q, ds_q, rw_q, w16_q, lsb_q, mode_q} = ctl_q;

  // ==========================================================
  // Strobe and address decode
  logic       rd_req;
  logic       wr_req;
  logic       active;
  logic [7:0] word_q;
  logic       mapped;

  assign rd_req = mode_q ? (!ds_q && rw_q) : !rd_q;
  assign wr_req = mode_q ? (!ds_q && !rw_q) : !wr_q;
  assign active = !cs_q && (rd_req || wr_req);
  assign word_q = {addr_q, 1'b0};

  always_comb
  begin
    case (word_q)
      `HBBC_OFF_ID, `HBBC_OFF_GCR1, `HBBC_OFF_GCR2, `HBBC_OFF_GIOCR,
      `HBBC_OFF_PCR1, `HBBC_OFF_PCR2, `HBBC_OFF_PCR3, `HBBC_OFF_PCR4,
      `HBBC_OFF_FIFOHEC, `HBBC_OFF_STAT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ==========================================================
  // Access sequencer
  hbbc_pkg::hbbc_state_e state;
  logic [2:0] cnt;
  logic [7:0] acc_word;
  logic       acc_wr;
  logic       acc_w16;
  logic       acc_swap;
  logic       acc_byte_hi;
  logic [15:0] acc_data;
  logic       do_acc;
  logic       wr_stb;
  logic       rd_stb;

  assign do_acc = (state == hbbc_pkg::ST_WAIT) && (cnt == 3'h0);
  assign wr_stb = do_acc && acc_wr;
  assign rd_stb = do_acc && !acc_wr;

  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      state       <= hbbc_pkg::ST_IDLE;
      cnt         <= 3'h0;
      acc_word    <= 8'h00;
      acc_wr      <= 1'b0;
      acc_w16     <= 1'b0;
      acc_swap    <= 1'b0;
      acc_byte_hi <= 1'b0;
      acc_data    <= 16'h0000;
    end
    else
    begin
      unique case (state)
        hbbc_pkg::ST_IDLE:
        begin
          if (active)
          begin
            acc_word    <= word_q;
            acc_wr      <= wr_req;
            acc_w16     <= w16_q;
            acc_swap    <= w16_q && lsb_q;
            acc_byte_hi <= !w16_q && lsb_q;
            acc_data    <= data_q;
            cnt         <= (word_q >= `HBBC_PORT_BASE) ? `HBBC_PORT_WAIT_CYC
                                                       : `HBBC_GLB_WAIT_CYC;
            state       <= mapped ? hbbc_pkg::ST_WAIT : hbbc_pkg::ST_HOLD;
          end
        end
        hbbc_pkg::ST_WAIT:
        begin
          if (cnt == 3'h0)
            state <= hbbc_pkg::ST_DONE;
          else
            cnt <= cnt - 3'h1;
        end
        hbbc_pkg::ST_DONE, hbbc_pkg::ST_HOLD:
        begin
          if (!active)
            state <= hbbc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Write lanes
  logic [15:0] wr_word;
  logic [15:0] wr_mask;

  always_comb
  begin
    if (acc_w16)
    begin
      wr_word = acc_swap ? {acc_data[7:0], acc_data[15:8]} : acc_data;
      wr_mask = 16'hffff;
    end
    else
    begin
      wr_word = {acc_data[7:0], acc_data[7:0]};
      wr_mask = acc_byte_hi ? 16'hff00 : 16'h00ff;
    end
  end

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] w,
                                        input logic [15:0] m);
    merge = (old & ~m) | (w & m);
  endfunction : merge

  // ==========================================================
  // Configuration registers
  logic [15:0] gcr1, gcr2, giocr, pcr1, pcr2, pcr3, pcr4, fifohec;
  logic [EVT_W-1:0] lat;
  logic        srst;
  logic        lcm;

  assign srst = gcr1[`HBBC_GCR1_RST];
  assign lcm  = gcr1[`HBBC_GCR1_LCM];

  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
      gcr1 <= `HBBC_GCR1_RST_VAL;
    else if (wr_stb && acc_word == `HBBC_OFF_GCR1)
      gcr1 <= merge(gcr1, wr_word, wr_mask);
    else if (srst)
      gcr1 <= `HBBC_GCR1_RST_VAL;
  end

  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      gcr2    <= `HBBC_ZERO_VAL;
      giocr   <= `HBBC_ZERO_VAL;
      pcr1    <= `HBBC_PCR1_RST_VAL;
      pcr2    <= `HBBC_ZERO_VAL;
      pcr3    <= `HBBC_ZERO_VAL;
      pcr4    <= `HBBC_ZERO_VAL;
      fifohec <= `HBBC_ZERO_VAL;
    end
    else if (srst)
    begin
      gcr2    <= `HBBC_ZERO_VAL;
      giocr   <= `HBBC_ZERO_VAL;
      pcr1    <= `HBBC_PCR1_RST_VAL;
      pcr2    <= `HBBC_ZERO_VAL;
      pcr3    <= `HBBC_ZERO_VAL;
      pcr4    <= `HBBC_ZERO_VAL;
      fifohec <= `HBBC_ZERO_VAL;
    end
    else if (wr_stb)
    begin
      case (acc_word)
        `HBBC_OFF_GCR2:    gcr2    <= merge(gcr2, wr_word, wr_mask);
        `HBBC_OFF_GIOCR:   giocr   <= merge(giocr, wr_word, wr_mask);
        `HBBC_OFF_PCR1:    pcr1    <= merge(pcr1, wr_word, wr_mask);
        `HBBC_OFF_PCR2:    pcr2    <= merge(pcr2, wr_word, wr_mask);
        `HBBC_OFF_PCR3:    pcr3    <= merge(pcr3, wr_word, wr_mask);
        `HBBC_OFF_PCR4:    pcr4    <= merge(pcr4, wr_word, wr_mask);
        `HBBC_OFF_FIFOHEC: fifohec <= merge(fifohec, wr_word, wr_mask);
        default:           ;
      endcase
    end
  end

  // ==========================================================
  // Latched status
  logic [15:0]      rd_word;
  logic [EVT_W-1:0] stat_clr;

  always_comb
  begin
    stat_clr = '0;
    if (acc_word == `HBBC_OFF_STAT)
    begin
      if (rd_stb && lcm)
        stat_clr = lat;
      else if (wr_stb && !lcm)
        stat_clr = wr_word[EVT_W-1:0] & wr_mask[EVT_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
      lat <= '0;
    else if (srst)
      lat <= '0;
    else
      lat <= (lat & ~stat_clr) | status_event;
  end

  // ==========================================================
  // Read path
  always_comb
  begin
    rd_word = 16'h0000;
    case (acc_word)
      `HBBC_OFF_ID:      rd_word = CHIP_ID;
      `HBBC_OFF_GCR1:    rd_word = gcr1;
      `HBBC_OFF_GCR2:    rd_word = gcr2;
      `HBBC_OFF_GIOCR:   rd_word = giocr;
      `HBBC_OFF_PCR1:    rd_word = pcr1;
      `HBBC_OFF_PCR2:    rd_word = pcr2;
      `HBBC_OFF_PCR3:    rd_word = pcr3;
      `HBBC_OFF_PCR4:    rd_word = pcr4;
      `HBBC_OFF_FIFOHEC: rd_word = fifohec;
      `HBBC_OFF_STAT:    rd_word[EVT_W-1:0] = lat;
      default:           rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      data_out <= 16'h0000;
      data_oe  <= 2'b00;
      rdy_n    <= 1'b1;
    end
    else if (do_acc)
    begin
      rdy_n <= 1'b0;
      if (!acc_wr)
      begin
        if (acc_w16)
        begin
          data_out <= acc_swap ? {rd_word[7:0], rd_word[15:8]} : rd_word;
          data_oe  <= 2'b11;
        end
        else
        begin
          data_out <= {8'h00, acc_byte_hi ? rd_word[15:8] : rd_word[7:0]};
          data_oe  <= 2'b01;
        end
      end
    end
    else if (state == hbbc_pkg::ST_DONE && !active)
    begin
      rdy_n   <= 1'b1;
      data_oe <= 2'b00;
    end
  end

  // ==========================================================
  // Configuration outputs
  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      device_run       <= 1'b0;
      tx_clock_pick    <= hbbc_pkg::TXCLK_RATE_ADAPTER;
      hec_pass_through <= 1'b0;
    end
    else
    begin
      device_run <= !srst;
      if (pcr3[`HBBC_PCR3_LOOP_TIMING_SELECT])
        tx_clock_pick <= hbbc_pkg::TXCLK_LOOP_RX;
      else if (pcr3[`HBBC_PCR3_TX_CLOCK_SOURCE_SELECT])
        tx_clock_pick <= hbbc_pkg::TXCLK_INPUT;
      else
        tx_clock_pick <= hbbc_pkg::TXCLK_RATE_ADAPTER;
      hec_pass_through <= fifohec[`HBBC_FH_TX_HEADER_CHECK_PASS] && fifohec[`HBBC_FH_RX_HEADER_CHECK_PASS];
    end
  end

  assign sys_if_type    = gcr1[`HBBC_GCR1_IFT +: `HBBC_W_IFT];
  assign sys_bus_width  = gcr1[`HBBC_GCR1_BUSW +: `HBBC_W_BUSW];
  assign global_datapath_hold = gcr1[`HBBC_GCR1_DPHOLD];
  assign port_datapath_hold   = pcr1[`HBBC_PCR1_DPHOLD];
  assign port_power_down      = pcr1[`HBBC_PCR1_PD];
  assign clock_rate_adapter_config          = gcr2;
  assign gio_config           = giocr;
  assign port_aux_config      = pcr4;
  assign payload_alarm_disable = pcr1[`HBBC_PCR1_PAYLOAD_ALARM_DISABLE +: `HBBC_W_PAYLOAD_ALARM_DISABLE];
  assign line_alarm_disable    = pcr1[`HBBC_PCR1_LINE_ALARM_DISABLE +: `HBBC_W_LINE_ALARM_DISABLE];
  assign hdlc_path_select      = pcr1[`HBBC_PCR1_HDLC_PATH_SELECT];
  assign line_interface_mode   = pcr2[`HBBC_PCR2_LM +: `HBBC_W_LM];
  assign framing_protocol_field = pcr2[`HBBC_PCR2_FM +: `HBBC_W_FM];
  assign cell_in_packet_mode_enable = pcr2[`HBBC_PCR2_CELL_IN_PACKET_MODE_ENABLE];
  assign tx_line_enable        = pcr2[`HBBC_PCR2_TX_LINE_ENABLE];
  assign tx_fifo_clear         = fifohec[`HBBC_FH_TX_FIFO_CLEAR];
  assign rx_fifo_clear         = fifohec[`HBBC_FH_RX_FIFO_CLEAR];

  // ==========================================================
  // Assertions
  localparam int GLB_RDY_DLY  = 3;
  localparam int PORT_RDY_DLY = 5;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n_s);

  unmapped_silent_a:
    assert property (state == hbbc_pkg::ST_HOLD |-> rdy_n)
    else $error("ready asserted for unmapped address");

  glb_ready_time_a:
    assert property (state == hbbc_pkg::ST_IDLE && active && mapped
                     && word_q < `HBBC_PORT_BASE |-> ##GLB_RDY_DLY $fell(rdy_n))
    else $error("global register ready at wrong cycle");

  port_ready_time_a:
    assert property (state == hbbc_pkg::ST_IDLE && active && mapped
                     && word_q >= `HBBC_PORT_BASE |-> ##PORT_RDY_DLY $fell(rdy_n))
    else $error("port register ready at wrong cycle");

  clear_write_a:
    assert property (wr_stb && acc_word == `HBBC_OFF_STAT && !lcm && !srst |=>
                     lat == (($past(lat) & ~($past(wr_word[EVT_W-1:0])
                                             & $past(wr_mask[EVT_W-1:0])))
                             | $past(status_event)))
    else $error("clear on write result wrong");

  clear_read_a:
    assert property (rd_stb && acc_word == `HBBC_OFF_STAT && lcm && !srst |=>
                     lat == $past(status_event))
    else $error("clear on read result wrong");

  event_sticky_a:
    assert property (lat[0] && !stat_clr[0] && !srst |=> lat[0])
    else $error("latched bit lost without clear");

  soft_reset_a:
    assert property (srst |=> pcr1 == `HBBC_PCR1_RST_VAL && lat == '0 && !device_run)
    else $error("global reset bit did not restore defaults");

  swap_read_a:
    assert property (rd_stb && acc_w16 && acc_swap |=>
                     data_out == {$past(rd_word[7:0]), $past(rd_word[15:8])} && data_oe == 2'b11)
    else $error("swapped read lanes wrong");

  byte_read_a:
    assert property (rd_stb && !acc_w16 |=> data_oe == 2'b01 && data_out[15:8] == 8'h00)
    else $error("8-bit read drives upper lanes");

  txclk_pick_a:
    assert property (pcr3[`HBBC_PCR3_LOOP_TIMING_SELECT] ##1 pcr3[`HBBC_PCR3_LOOP_TIMING_SELECT] |->
                     tx_clock_pick == hbbc_pkg::TXCLK_LOOP_RX)
    else $error("loop timing not selected");

  hec_pass_a:
    assert property (hec_pass_through == ($past(fifohec[`HBBC_FH_TX_HEADER_CHECK_PASS])
                                          && $past(fifohec[`HBBC_FH_RX_HEADER_CHECK_PASS])))
    else $error("header check passed without both bits");
endmodule : hbbc_host_port
`default_nettype wire

// ---- hbbc_host_model.sv ----
// Host processor model for the asynchronous register port
`timescale 1ns/1ps
`default_nettype none
module hbbc_host_model (
  input  wire logic        mclk,
  input  wire logic        strobe_mode,
  input  wire logic        rdy_n,
  input  wire logic [15:0] data_out,
  input  wire logic [1:0]  data_oe,
  output var  logic        cs_n,
  output var  logic        rd_n,
  output var  logic        wr_n,
  output var  logic        ds_n,
  output var  logic        rw_dir,
  output var  logic        addr_bit0,
  output var  logic [6:0]  addr,
  output var  logic [15:0] data_in
);
  initial
  begin
    {cs_n, rd_n, wr_n, ds_n, rw_dir, addr_bit0} = 6'h3e;
    addr = 7'h00;
    data_in = 16'h0000;
  end
  // ==========
  // Bus cycle; lat is -1 when ready never comes
  task automatic access(input logic w, input logic [7:0] off, input logic [15:0] wd,
                        output logic [15:0] rd, output logic [1:0] oe, output int lat);
    int n;
    n = 0;
    lat = 0;
    @(posedge mclk);
    addr      <= off[7:1];
    addr_bit0 <= off[0];
    data_in   <= wd;
    rw_dir    <= ~w;
    cs_n      <= 1'b0;
    ds_n      <= ~strobe_mode;
    wr_n      <= strobe_mode | ~w;
    rd_n      <= strobe_mode | w;
    do
    begin
      @(posedge mclk);
      lat++;
    end
    while (rdy_n !== 1'b0 && lat < 30);
    rd = data_out;  // Taken at the ready edge
    oe = data_oe;
    if (rdy_n !== 1'b0)
      lat = -1;
    {cs_n, rd_n, wr_n, ds_n} <= 4'hf;
    data_in <= ~wd;  // No stale value on a released bus
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (rdy_n !== 1'b1 && n < 30);
    if (rdy_n !== 1'b1)
      lat = -1;
    @(posedge mclk);
  endtask : access
endmodule : hbbc_host_model
`default_nettype wire

// ---- host_bus_and_bringup_config_tb.sv ----
// Self-checking bench of the host port and bring-up registers
`timescale 1ns/1ps
`default_nettype none
module host_bus_and_bringup_config_tb;
  logic        mclk, arst_n, width_sel_pin, swap, strobe_mode_pin, rdy_n, device_run;
  logic        cs_n, rd_n, wr_n, ds_n, rw_dir, addr_bit0, hdlc_path_select, tx_line_enable;
  logic        global_datapath_hold, port_datapath_hold, port_power_down, hec_pass_through;
  logic        tx_fifo_clear, rx_fifo_clear, cell_in_packet_mode_enable;
  logic [1:0]  data_oe, sys_if_type, sys_bus_width, line_alarm_disable, tx_clock_pick, oe;
  logic [2:0]  payload_alarm_disable;
  logic [3:0]  line_interface_mode;
  logic [5:0]  framing_protocol_field;
  logic [6:0]  addr;
  logic [15:0] data_in, data_out, status_event, clock_rate_adapter_config, gio_config, port_aux_config, rdv;
  wire logic   addr_lsb_or_swap_pin;
  int          err_count, checks_done, lat, lat_g;
  localparam logic [39:0] ROWS [20] = '{
    40'h02_0000_0000, 40'h02_0500_0005, 40'h02_0a00_000a, 40'h02_0300_0003,
    40'h04_0204_0204, 40'h0a_a5c3_a5c3, 40'h40_0010_0004, 40'h40_7c00_00f8,
    40'h44_0000_0000, 40'h44_0002_0001, 40'h44_0001_0002, 40'h44_0003_0002,
    40'h42_0306_0306, 40'h42_0fff_0fff, 40'h48_0003_0006, 40'h48_0000_0000,
    40'h46_1234_1234, 40'h48_000c_0001, 40'h48_0004_0000, 40'h42_0001_0001
  };

  assign addr_lsb_or_swap_pin = width_sel_pin ? swap : addr_bit0;

  hbbc_host_port #(.CHIP_ID(16'h00c3)) uut (  // Arbitrary identity value
    .mclk, .arst_n, .width_sel_pin, .addr_lsb_or_swap_pin, .strobe_mode_pin, .cs_n, .rd_n,
    .wr_n, .ds_n, .rw_dir, .addr, .data_in, .data_out, .data_oe, .rdy_n, .status_event,
    .device_run, .sys_if_type, .sys_bus_width, .global_datapath_hold, .port_datapath_hold,
    .port_power_down, .clock_rate_adapter_config, .gio_config, .port_aux_config, .payload_alarm_disable,
    .line_alarm_disable, .hdlc_path_select, .line_interface_mode, .framing_protocol_field,
    .cell_in_packet_mode_enable, .tx_line_enable, .tx_clock_pick, .tx_fifo_clear,
    .rx_fifo_clear, .hec_pass_through
  );
  hbbc_host_model host (
    .mclk, .strobe_mode(strobe_mode_pin), .rdy_n, .data_out, .data_oe, .cs_n, .rd_n,
    .wr_n, .ds_n, .rw_dir, .addr_bit0, .addr, .data_in
  );

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ==========
  // Helpers
  function automatic logic [15:0] obs(input logic [7:0] off);
    case (off)
      8'h02: return {12'h0, sys_bus_width, sys_if_type};
      8'h04: return clock_rate_adapter_config;
      8'h0a: return gio_config;
      8'h40: return {8'h0, payload_alarm_disable, line_alarm_disable, hdlc_path_select,
                     port_power_down, port_datapath_hold};
      8'h42: return {4'h0, line_interface_mode, cell_in_packet_mode_enable,
                     framing_protocol_field, tx_line_enable};
      8'h44: return {14'h0, tx_clock_pick};
      8'h46: return port_aux_config;
      default: return {13'h0, tx_fifo_clear, rx_fifo_clear, hec_pass_through};
    endcase
  endfunction : obs
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] off, input logic [15:0] v);
    host.access(w, off, v, rdv, oe, lat);
    if (lat < 0)
    begin
      err_count++;
      end_of_test();
    end
  endtask : xfer
  task automatic get(input logic [7:0] off, input logic [15:0] exp);
    xfer(1'b0, off, 16'h0);
    chk(width_sel_pin ? rdv : {8'h0, rdv[7:0]}, exp);
  endtask : get
  task automatic do_reset(input logic w, input logic s, input logic m);
    arst_n <= 1'b0;
    width_sel_pin <= w;
    swap <= s;
    strobe_mode_pin <= m;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : do_reset
  task automatic pulse(input logic [15:0] e);
    @(posedge mclk);
    status_event <= e;
    @(posedge mclk);
    status_event <= 16'h0;
  endtask : pulse

  // ==========
  // Main sequence
  initial
  begin
    err_count = 0;
    checks_done = 0;
    {arst_n, swap, width_sel_pin, strobe_mode_pin} = 4'h2;
    status_event = 16'h0;
    do_reset(1'b1, 1'b0, 1'b0);
    chk({9'h0, data_oe, rdy_n, device_run, global_datapath_hold, port_datapath_hold,
         port_power_down}, 16'h0017);
    get(8'h00, 16'h00c3);
    get(8'h02, 16'h0003);
    lat_g = lat;
    xfer(1'b1, 8'h40, 16'h7c00);
    get(8'h40, 16'h0003);
    chk(16'(lat - lat_g), 16'h0002);
    xfer(1'b1, 8'h02, 16'h0000);
    chk({10'h0, device_run, global_datapath_hold, sys_bus_width, sys_if_type}, 16'h0020);
    foreach (ROWS[i])
    begin
      xfer(1'b1, ROWS[i][39:32], ROWS[i][31:16]);
      get(ROWS[i][39:32], ROWS[i][31:16]);
      chk(obs(ROWS[i][39:32]), ROWS[i][15:0]);
    end
    pulse(16'h0005);
    get(8'h4a, 16'h0005);
    get(8'h4a, 16'h0005);
    xfer(1'b1, 8'h4a, 16'h0001);
    get(8'h4a, 16'h0004);
    xfer(1'b1, 8'h02, 16'h0004);
    pulse(16'h0003);
    get(8'h4a, 16'h0007);
    get(8'h4a, 16'h0000);
    host.access(1'b0, 8'h20, 16'h0, rdv, oe, lat);
    chk(16'(lat), 16'hffff);
    xfer(1'b1, 8'h02, 16'h0001);
    get(8'h46, 16'h0000);
    get(8'h02, 16'h0003);
    chk({15'h0, device_run}, 16'h0000);
    do_reset(1'b1, 1'b1, 1'b0);
    xfer(1'b1, 8'h02, 16'h0000);
    xfer(1'b1, 8'h46, 16'h3412);
    chk(port_aux_config, 16'h1234);
    get(8'h47, 16'h3412);
    chk({14'h0, oe}, 16'h0003);
    do_reset(1'b0, 1'b0, 1'b1);
    xfer(1'b1, 8'h02, 16'h0000);
    xfer(1'b1, 8'h47, 16'h0012);
    xfer(1'b1, 8'h46, 16'h0034);
    chk(port_aux_config, 16'h1234);
    get(8'h47, 16'h0012);
    chk({14'h0, oe}, 16'h0001);
    end_of_test();
  end
endmodule : host_bus_and_bringup_config_tb
`default_nettype wire
